/* File: hdl/wdt_core.sv */
// watchdog timer: enable control, counter, prewarning and reset request
`timescale 1ns/1ps
`include "wdt_regs.svh"
module wdt_core (
  input  wire logic                      core_clk_i,    // system clock, 50 MHz
  input  wire logic                      arst_n_i,      // async reset, active low
  input  wire logic                      ce_i,          // clock enable, freezes all state
  input  wire logic                      service_i,     // service instruction strobe
  input  wire logic                      disable_i,     // watchdog_disable_instruction strobe
  input  wire logic                      enable_i,      // watchdog_enable_instruction strobe
  input  wire logic                      cfg_we_i,      // write reload value and ratio
  input  wire logic [`WDT_RELOAD_W-1:0]  cfg_reload_i,  // new reload value
  input  wire wdt_pkg::wdt_presc_e       cfg_presc_i,   // new prescaler ratio
  output logic                           enabled_o,     // watchdog enabled
  output logic [`WDT_CNT_W-1:0]          count_o,       // counter value
  output logic [`WDT_RELOAD_W-1:0]       reload_o,      // reload_value_register contents
  output logic                           prewarn_o,     // prewarning interrupt pulse
  output logic                           reset_req_o    // reset request, held till reset
);
  import wdt_pkg::*;

  localparam int unsigned PREWARN_CYC = `WDT_PREWARN_CYC;
  localparam int unsigned WAIT_LAST_I = PREWARN_CYC - 1;
  localparam logic [`WDT_WAIT_W-1:0] WAIT_LAST = WAIT_LAST_I[`WDT_WAIT_W-1:0];

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  wdt_state_e              state;
  wdt_state_e              next_state;
  wdt_presc_e              presc_sel;
  logic [`WDT_WAIT_W-1:0]  wait_cnt;
  logic                    tick;

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  // once the reset request is up only a new reset clears it; services are refused
  wire                     live       = state != WDT_RESREQ;
  wire                     run        = enabled_o && live;
  wire                     srv_hit    = service_i && live;
  wire                     ovf_fire   = run && tick && (count_o == `WDT_CNT_MAX);
  wire                     wait_done  = wait_cnt == WAIT_LAST;
  // reload fills the high byte only, so the shortest interval is 256 ticks
  wire [`WDT_CNT_W-1:0]    load_val   = {reload_o, `WDT_LOW_FILL};
  // enable beats disable in the same cycle: fail-safe side wins
  wire                     next_en    = enable_i ? 1'b1 : (disable_i ? 1'b0 : enabled_o);
  wire [`WDT_CNT_W-1:0]    next_count = srv_hit ? load_val : (run && tick ? count_o + 1'b1 : count_o);
  wire [`WDT_WAIT_W-1:0]   next_wait  = (state == WDT_PREWARN) ? wait_cnt + 1'b1 : '0;

  // the prescaler tick is combinational; everything the core drives out is registered
  wdt_prescaler u_presc (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .run_i      (run),
    .clr_i      (srv_hit),
    .sel_i      (presc_sel),
    .tick_o     (tick)
  );

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      WDT_RUN: begin
        if (ovf_fire && !srv_hit) begin
          next_state = WDT_PREWARN;
        end
      end
      WDT_PREWARN: begin
        // a late service or a disable still rescues the system
        if (srv_hit || !enabled_o) begin
          next_state = WDT_RUN;
        end else if (wait_done) begin
          next_state = WDT_RESREQ;
        end
      end
      WDT_RESREQ: begin
        next_state = WDT_RESREQ;
      end
      // the fourth code is illegal; a corrupted state fails safe into the reset request
      default: begin
        next_state = WDT_RESREQ;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // ce_i low freezes every flop, prescaler included, so an interval resumes where it stopped
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enabled_o <= 1'b1;
      state     <= WDT_RUN;
      wait_cnt  <= '0;
    end else if (ce_i) begin
      enabled_o <= next_en;
      state     <= next_state;
      wait_cnt  <= next_wait;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_o <= {`WDT_RELOAD_RST, `WDT_LOW_FILL};
    end else if (ce_i) begin
      count_o <= next_count;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reload_o  <= `WDT_RELOAD_RST;
      presc_sel <= wdt_presc_e'(`WDT_PRESC_RST);
    end else if (ce_i && cfg_we_i) begin
      reload_o  <= cfg_reload_i;
      presc_sel <= cfg_presc_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prewarn_o   <= 1'b0;
      reset_req_o <= 1'b0;
    end else if (ce_i) begin
      prewarn_o   <= (state == WDT_RUN) && (next_state == WDT_PREWARN);
      reset_req_o <= next_state == WDT_RESREQ;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  // helper flags: first cycle after reset, any config write, warning pending
  logic first_cyc;
  logic cfg_seen;
  logic warned;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_cyc <= 1'b1;
      cfg_seen  <= 1'b0;
      warned    <= 1'b0;
    end else if (ce_i) begin
      first_cyc <= 1'b0;
      cfg_seen  <= cfg_seen || cfg_we_i;
      warned    <= prewarn_o || (warned && state != WDT_RUN);
    end
  end

  // all checks share the one clock; a reset aborts every attempt in flight
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_ENABLED_AFTER_RESET: assert property (first_cyc |-> enabled_o && !reset_req_o)
    else $error("watchdog not enabled after reset");
  AST_DISABLE_TAKES: assert property (ce_i && disable_i && !enable_i |=> !enabled_o)
    else $error("disable instruction ignored");
  AST_ENABLE_TAKES: assert property (ce_i && enable_i |=> enabled_o)
    else $error("enable instruction ignored");
  AST_OVF_PREWARN: assert property (ce_i && ovf_fire && state == WDT_RUN && !service_i
                                    |=> prewarn_o && count_o == '0)
    else $error("overflow without prewarning or wrap");
  AST_PREWARN_BEFORE_RESET: assert property ($rose(reset_req_o) |-> warned && !prewarn_o)
    else $error("reset request without prior prewarning");
  AST_TICK_ADVANCE: assert property (ce_i && run && tick && !service_i
                                     |=> count_o == $past(count_o) + 16'h0001)
    else $error("counter did not advance on tick");
  AST_SERVICE_RELOAD: assert property (ce_i && srv_hit
                                       |=> count_o == {$past(reload_o), `WDT_LOW_FILL} && !tick)
    else $error("service did not reload counter and clear prescaler");
  AST_RELOAD_WRITE: assert property (ce_i && cfg_we_i |=> reload_o == $past(cfg_reload_i))
    else $error("reload value not stored");
  AST_DEFAULTS: assert property (!cfg_seen |-> reload_o == `WDT_RELOAD_RST
                                 && presc_sel == WDT_DIV_256)
    else $error("reset defaults changed without write");
  AST_DIV256_TICK: assert property (ce_i && run && presc_sel == WDT_DIV_256 && tick
                                    |=> !tick)
    else $error("prescaler ticks back to back");
  AST_HOLD_DISABLED: assert property (!enabled_o && !service_i
                                      |=> $stable(count_o) && !prewarn_o)
    else $error("disabled watchdog still counting or warning");
  AST_PREWARN_PULSE: assert property (prewarn_o && ce_i |=> !prewarn_o)
    else $error("prewarning interrupt longer than one cycle");
  AST_PREWARN_IN_STATE: assert property (prewarn_o |-> state == WDT_PREWARN)
    else $error("prewarning interrupt outside the warning phase");
  AST_RESREQ_HOLDS: assert property (reset_req_o |=> reset_req_o)
    else $error("reset request dropped before reset");
  AST_RESREQ_FROM_PREWARN: assert property (!reset_req_o && state != WDT_PREWARN |=> !reset_req_o)
    else $error("reset request without a warning phase");
  AST_RESREQ_REFUSES: assert property (reset_req_o |=> $stable(count_o))
    else $error("counter moved after reset request");
  AST_NO_RESREQ_DISABLED: assert property (!enabled_o && !reset_req_o |=> !reset_req_o)
    else $error("disabled watchdog raised a reset request");
  AST_COUNT_ONLY_ON_TICK: assert property (ce_i && !tick && !srv_hit |=> $stable(count_o))
    else $error("counter moved without a tick");
  AST_EN_STABLE: assert property (!enable_i && !disable_i |=> $stable(enabled_o))
    else $error("enable state changed without an instruction");
  AST_RELOAD_HOLDS: assert property (!cfg_we_i |=> $stable(reload_o))
    else $error("reload value changed without a write");
  AST_RATIO_WRITE: assert property (ce_i && cfg_we_i |=> presc_sel == $past(cfg_presc_i))
    else $error("prescaler ratio not stored");
  AST_CE_FREEZE: assert property (!ce_i |=> $stable(count_o) && $stable(enabled_o)
                                  && $stable(reload_o) && $stable(state))
    else $error("state moved while clock enable low");
  AST_RESET_COUNT: assert property (first_cyc |-> count_o == {`WDT_RELOAD_RST, `WDT_LOW_FILL})
    else $error("counter not at default start after reset");
  AST_OVF_AT_MAX: assert property ($rose(prewarn_o) |-> $past(count_o) == `WDT_CNT_MAX)
    else $error("prewarning without counter at all ones");

  // --------------------------------------------------------------------------
  // coverage
  // --------------------------------------------------------------------------
  COV_SERVICE: cover property (srv_hit && ce_i);
  COV_PREWARN: cover property (prewarn_o);
  COV_RESET_REQ: cover property ($rose(reset_req_o));
  COV_RESCUE: cover property (state == WDT_PREWARN && srv_hit && ce_i);
  COV_FREEZE: cover property (!ce_i && enabled_o);
endmodule // wdt_core

/* File: common/wdt_regs.svh */
// timing counts, reset values and field positions of the watchdog timer
// What this block does
// - after any application reset the watchdog runs and monitors without software help
// - disable and enable instructions switch the watchdog off and on at any time before the reset request
// - on overflow first raise a prewarning interrupt, afterwards a reset request
// - sixteen-bit counter advancing on a prescaled tick, divide by 256 or 16384
// - loading takes the start count from the programmable reload value register
// - each service before the reset request reloads the counter and clears the prescaler together
// - reset defaults give about 6.5 ms interval at a 10 MHz system clock
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------------------------------------------
// widths and fields
// ----------------------------------------------------------------------------
`define WDT_CNT_W        16
`define WDT_PRESC_W      14
`define WDT_RELOAD_W     8
`define WDT_RELOAD_LSB   8
`define WDT_CNT_MAX      16'hffff
`define WDT_LOW_FILL     8'h00
`define WDT_DIV256_MASK  14'h00ff
`define WDT_DIV16K_MASK  14'h3fff

// ----------------------------------------------------------------------------
// reset values: 256 ticks of 256 clocks, 6.55 ms at 10 MHz
// ----------------------------------------------------------------------------
`define WDT_DEF_INTERVAL_US 6500
`define WDT_DEF_FSYS_KHZ    10000
`define WDT_RELOAD_RST      8'hff
`define WDT_PRESC_RST       1'b0

// ----------------------------------------------------------------------------
// timing: delay between prewarning and reset request
// ----------------------------------------------------------------------------
`define WDT_CLK_PERIOD_NS   20
`define WDT_PREWARN_NS      1000
`define WDT_PREWARN_CYC     ((`WDT_PREWARN_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)
`define WDT_WAIT_W          6

`endif

/* File: common/wdt_pkg.sv */
// types shared by the watchdog timer files
package wdt_pkg;
  typedef enum logic {
    WDT_DIV_256,
    WDT_DIV_16384
  } wdt_presc_e;

  typedef enum logic [1:0] {
    WDT_RUN,
    WDT_PREWARN,
    WDT_RESREQ
  } wdt_state_e;
endpackage

/* File: hdl/wdt_prescaler.sv */
// selectable system clock prescaler producing the watchdog tick
`timescale 1ns/1ps
`include "wdt_regs.svh"
module wdt_prescaler (
  input  wire logic               core_clk_i, // system clock
  input  wire logic               arst_n_i,   // async reset, active low
  input  wire logic               ce_i,       // clock enable
  input  wire logic               run_i,      // count while high
  input  wire logic               clr_i,      // clear to zero
  input  wire wdt_pkg::wdt_presc_e sel_i,     // division ratio
  output logic                    tick_o      // one-cycle tick
);
  import wdt_pkg::*;

  logic [`WDT_PRESC_W-1:0] cnt;
  wire  [`WDT_PRESC_W-1:0] term_mask;
  wire  [`WDT_PRESC_W-1:0] next_cnt;

  assign term_mask = (sel_i == WDT_DIV_16384) ? `WDT_DIV16K_MASK : `WDT_DIV256_MASK;
  // terminal count of the selected low bits; upper bits ignored for div 256
  assign tick_o    = run_i && !clr_i && ((cnt & term_mask) == term_mask);
  assign next_cnt  = clr_i ? '0 : (run_i ? cnt + 1'b1 : cnt);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      cnt <= next_cnt;
    end
  end
endmodule // wdt_prescaler

/* File: testbench/watchdog_timer_tb.sv */
// self-checking testbench for the watchdog timer core
`timescale 1ns/1ps
`include "wdt_regs.svh"
module watchdog_timer_tb;
  import wdt_pkg::*;
  logic                     core_clk_i;
  logic                     arst_n_i;
  logic                     ce_i;
  logic                     service_i;
  logic                     disable_i;
  logic                     enable_i;
  logic                     cfg_we_i;
  logic [`WDT_RELOAD_W-1:0] cfg_reload_i;
  wdt_presc_e               cfg_presc_i;
  logic                     enabled_o;
  logic [`WDT_CNT_W-1:0]    count_o;
  logic [`WDT_RELOAD_W-1:0] reload_o;
  logic                     prewarn_o;
  logic                     reset_req_o;
  int                       failures;
  int                       comparisons;

  wdt_core DUT (
    .core_clk_i   (core_clk_i),
    .arst_n_i     (arst_n_i),
    .ce_i         (ce_i),
    .service_i    (service_i),
    .disable_i    (disable_i),
    .enable_i     (enable_i),
    .cfg_we_i     (cfg_we_i),
    .cfg_reload_i (cfg_reload_i),
    .cfg_presc_i  (cfg_presc_i),
    .enabled_o    (enabled_o),
    .count_o      (count_o),
    .reload_o     (reload_o),
    .prewarn_o    (prewarn_o),
    .reset_req_o  (reset_req_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // inputs always change 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0b seen %0b", name, exp, got);
    end
  endtask

  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic strobe(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic cfg(input logic [7:0] rl, input wdt_presc_e ps);
    cfg_reload_i = rl;
    cfg_presc_i  = ps;
    strobe(cfg_we_i);
  endtask

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic test_reset;
    chk_bit("enabled", 1'b1, enabled_o);
    chk_val("count", 16'hff00, count_o);
    chk_val("reload", 16'h00ff, {8'h00, reload_o});
    chk_bit("reset_req", 1'b0, reset_req_o);
    step(255);
    chk_val("count", 16'hff00, count_o);
    step(1);
    chk_val("count", 16'hff01, count_o);
  endtask

  // prescaler left mid-way first, so a missing clear shifts the tick
  task automatic test_service(input wdt_presc_e ps, input int div);
    cfg(8'h80, ps);
    chk_val("reload", 16'h0080, {8'h00, reload_o});
    step(100);
    strobe(service_i);
    chk_val("count", 16'h8000, count_o);
    step(div - 1);
    chk_val("count", 16'h8000, count_o);
    step(1);
    chk_val("count", 16'h8001, count_o);
  endtask

  // disable one cycle after a service: prescaler holds at 1, so the tick comes 255 cycles after enable
  task automatic test_disable;
    cfg(8'h80, WDT_DIV_256);
    strobe(service_i);
    strobe(disable_i);
    chk_bit("enabled", 1'b0, enabled_o);
    chk_val("count", 16'h8000, count_o);
    step(600);
    chk_val("count", 16'h8000, count_o);
    chk_bit("prewarn", 1'b0, prewarn_o);
    strobe(enable_i);
    chk_bit("enabled", 1'b1, enabled_o);
    step(254);
    chk_val("count", 16'h8000, count_o);
    step(1);
    chk_val("count", 16'h8001, count_o);
    disable_i = 1'b1;
    enable_i  = 1'b1;
    step(1);
    disable_i = 1'b0;
    enable_i  = 1'b0;
    step(1);
    chk_bit("enabled", 1'b1, enabled_o);
  endtask

  // instructions and writes offered while ce_i is low must be lost, and the tick only delayed
  task automatic test_freeze;
    strobe(service_i);
    ce_i         = 1'b0;
    disable_i    = 1'b1;
    cfg_reload_i = 8'h11;
    cfg_we_i     = 1'b1;
    step(100);
    ce_i      = 1'b1;
    disable_i = 1'b0;
    cfg_we_i  = 1'b0;
    chk_bit("enabled", 1'b1, enabled_o);
    chk_val("reload", 16'h0080, {8'h00, reload_o});
    step(255);
    chk_val("count", 16'h8000, count_o);
    step(1);
    chk_val("count", 16'h8001, count_o);
  endtask

  task automatic test_overflow;
    int          n;
    logic [15:0] v;
    cfg(8'hff, WDT_DIV_256);
    strobe(service_i);
    n = 0;
    while (prewarn_o !== 1'b1 && n < 70000) begin
      step(1);
      n++;
    end
    if (n >= 70000) begin
      failures++;
      end_sim();
    end
    chk_bit("interval", 1'b1, n == 65536);
    chk_val("count", 16'h0000, count_o);
    chk_bit("reset_req", 1'b0, reset_req_o);
    step(1);
    chk_bit("prewarn", 1'b0, prewarn_o);
    n = 1;
    while (reset_req_o !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    chk_val("prewarn to reset", 16'd50, n[15:0]);
    strobe(service_i);
    chk_bit("reset_req", 1'b1, reset_req_o);
    v = count_o;
    step(300);
    chk_val("count", v, count_o);
  endtask

  initial begin
    failures     = 0;
    comparisons  = 0;
    arst_n_i     = 1'b0;
    ce_i         = 1'b1;
    service_i    = 1'b0;
    disable_i    = 1'b0;
    enable_i     = 1'b0;
    cfg_we_i     = 1'b0;
    cfg_reload_i = 8'hff;
    cfg_presc_i  = WDT_DIV_256;
    step(6);
    arst_n_i = 1'b1;
    test_reset();
    test_service(WDT_DIV_256, 256);
    test_service(WDT_DIV_16384, 16384);
    test_disable();
    test_freeze();
    test_overflow();
    arst_n_i = 1'b0;
    step(2);
    arst_n_i = 1'b1;
    test_reset();
    end_sim();
  end
endmodule // watchdog_timer_tb
